// [hw/wwdog_top.sv]
`timescale 1ns/1ps
`include "wwdog_map.svh"
module wwdog_top
  import wwdog_pkg::*;
#(
  parameter int PRE_DIV = `WWDOG_PRE_DIV
) (
  input  wire logic                    i_core_clk,
  input  wire logic                    i_reset_n,
  input  wire logic                    i_por,
  input  wire logic                    i_cfg_we,
  input  wire wwdog_cfg_t              i_cfg,
  input  wire wwdog_feed_t             i_feed,
  input  wire logic                    i_warn_clr,
  input  wire logic                    i_tout_clr,
  input  wire logic                    i_wdrst_flag_clr,
  output logic                         o_chip_reset,
  output logic                         o_wdog_irq,
  output logic                         o_warn_irq,
  output logic                         o_enabled,
  output logic                         o_timeout_flag,
  output logic                         o_wdrst_flag,
  output logic [`WWDOG_CNT_W-1:0]      o_count
);
  // =====================================================
  // reset release
  logic rst_s1_r;
  logic rst_n_r;
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rst_s1_r <= 1'b0;
      rst_n_r  <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_n_r  <= rst_s1_r;
    end
  end

  // =====================================================
  // power-on clear release
  // the clear takes hold at once but lets go on the clock, never mid-edge
  logic por_s1_r;
  logic por_r;
  always_ff @(posedge i_core_clk or posedge i_por) begin
    if (i_por) begin
      por_s1_r <= 1'b1;
      por_r    <= 1'b1;
    end else begin
      por_s1_r <= 1'b0;
      por_r    <= por_s1_r;
    end
  end

  // =====================================================
  // configuration
  logic                   en_r;
  logic                   rst_act_r;
  logic [`WWDOG_CNT_W-1:0] tc_r;
  logic [`WWDOG_CNT_W-1:0] win_r;
  logic [`WWDOG_CNT_W-1:0] warn_r;
  logic                   tick;
  logic                   fire;

  // software may only set enable; a watchdog event or a reset is the only way out
  wire en_nxt = fire ? 1'b0 : (en_r | (i_cfg_we & i_cfg.enable));
  // reset action, like enable, can only be armed
  wire rst_act_nxt = rst_act_r | (i_cfg_we & i_cfg.reset_act);

  always_ff @(posedge i_core_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      en_r      <= 1'b0;
      rst_act_r <= 1'b0;
      tc_r      <= `WWDOG_CNT_RST;
      win_r     <= `WWDOG_WIN_RST;
      warn_r    <= `WWDOG_WARN_RST;
    end else begin
      en_r      <= en_nxt;
      rst_act_r <= rst_act_nxt;
      if (i_cfg_we) begin
        tc_r   <= i_cfg.timeout;
        win_r  <= i_cfg.window;
        warn_r <= i_cfg.warn;
      end
    end
  end

  // =====================================================
  // feed sequence
  wwdog_feed_st_t fst_r;
  wire key1     = i_feed.valid && (i_feed.data == `WWDOG_FEED_KEY1);
  wire key2     = i_feed.valid && (i_feed.data == `WWDOG_FEED_KEY2);
  wire idle_bad = i_feed.valid && !key1;
  // an interleaved access between the two keys breaks the pair
  wire half_bad = (i_feed.valid && !key2) || i_feed.other_acc;
  wire feed_ok  = (fst_r == WWDOG_FEED_HALF) && key2 && !i_feed.other_acc;
  // the first key is kept for as long as no other watchdog access comes
  wire start_pair = (fst_r == WWDOG_FEED_IDLE) && key1;
  wire hold_pair  = (fst_r == WWDOG_FEED_HALF) && !i_feed.valid && !i_feed.other_acc;
  wwdog_feed_st_t fst_nxt;
  assign fst_nxt = (start_pair || hold_pair) ? WWDOG_FEED_HALF : WWDOG_FEED_IDLE;
  logic feed_bad;
  always_comb begin
    feed_bad = 1'b0;
    unique case (fst_r)
      WWDOG_FEED_IDLE: feed_bad = idle_bad;
      WWDOG_FEED_HALF: feed_bad = half_bad;
      default:         feed_bad = 1'b1;
    endcase
  end
  always_ff @(posedge i_core_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      fst_r <= WWDOG_FEED_IDLE;
    end else begin
      fst_r <= fst_nxt;
    end
  end

  // =====================================================
  // counter
  logic [`WWDOG_CNT_W-1:0] cnt_r;
  wwdog_prescale #(
    .DIV (PRE_DIV)
  ) u_pre (
    .i_core_clk (i_core_clk),
    .i_rst_n    (rst_n_r),
    .i_run      (en_r),
    .o_tick     (tick)
  );

  // a feed while the count is still above the window limit is too early
  wire too_early = feed_ok && (cnt_r > win_r);
  wire reload    = feed_ok && !too_early;
  // bad feeds only count once running, so set-up feeds cannot trip it
  wire bad_ev    = en_r && (feed_bad || too_early);
  wire expire    = en_r && tick && (cnt_r == '0);
  assign fire    = expire || bad_ev;
  wire warn_hit  = en_r && tick && (cnt_r == warn_r);

  // a write while stopped loads its own time-out, so enabling starts from it
  wire [`WWDOG_CNT_W-1:0] load_val = i_cfg_we ? i_cfg.timeout : tc_r;
  wire [`WWDOG_CNT_W-1:0] cnt_nxt = (reload || !en_r) ? load_val :
                                    (tick && cnt_r != '0) ? cnt_r - 1'b1 : cnt_r;

  always_ff @(posedge i_core_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      cnt_r <= `WWDOG_CNT_RST;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  // =====================================================
  // outputs; set wins over clear on every sticky flag
  wire tout_nxt = fire | (o_timeout_flag & ~i_tout_clr);
  wire warn_nxt = warn_hit | (o_warn_irq & ~i_warn_clr);
  wire irq_nxt  = (fire & ~rst_act_r) | (o_wdog_irq & ~i_tout_clr);

  wire crst_nxt = fire & rst_act_r;

  always_ff @(posedge i_core_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      o_chip_reset <= 1'b0;
    end else begin
      o_chip_reset <= crst_nxt;
    end
  end

  always_ff @(posedge i_core_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      o_wdog_irq <= 1'b0;
    end else begin
      o_wdog_irq <= irq_nxt;
    end
  end

  always_ff @(posedge i_core_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      o_warn_irq <= 1'b0;
    end else begin
      o_warn_irq <= warn_nxt;
    end
  end

  always_ff @(posedge i_core_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      o_enabled <= 1'b0;
    end else begin
      o_enabled <= en_nxt;
    end
  end

  always_ff @(posedge i_core_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      o_timeout_flag <= 1'b0;
    end else begin
      o_timeout_flag <= tout_nxt;
    end
  end

  always_ff @(posedge i_core_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      o_count <= `WWDOG_CNT_RST;
    end else begin
      o_count <= cnt_nxt;
    end
  end

  // the reset flag lives through the watchdog's own reset; only power-on or i_wdrst_flag_clr clears it
  always_ff @(posedge i_core_clk or posedge por_r) begin
    if (por_r) begin
      o_wdrst_flag <= 1'b0;
    end else begin
      o_wdrst_flag <= (fire & rst_act_r & en_r) | (o_wdrst_flag & ~i_wdrst_flag_clr);
    end
  end
endmodule

// [include/wwdog_map.svh]
`ifndef WWDOG_MAP_SVH
`define WWDOG_MAP_SVH
// =====================================================
// counter geometry
`define WWDOG_CNT_W        24
`define WWDOG_CNT_MAX      24'hFF_FFFF
`define WWDOG_CNT_RST      24'h00_00FF
`define WWDOG_WIN_RST      24'hFF_FFFF
`define WWDOG_WARN_RST     24'h00_0000
// =====================================================
// prescaler and feed keys
`define WWDOG_PRE_DIV      4
`define WWDOG_PRE_W        2
`define WWDOG_KEY_W        8
`define WWDOG_FEED_KEY1    8'hAA
`define WWDOG_FEED_KEY2    8'h55
`endif

// [include/wwdog_pkg.sv]
package wwdog_pkg;
  `include "wwdog_map.svh"

  typedef struct packed {
    logic                     enable;
    logic                     reset_act;
    logic [`WWDOG_CNT_W-1:0]  timeout;
    logic [`WWDOG_CNT_W-1:0]  window;
    logic [`WWDOG_CNT_W-1:0]  warn;
  } wwdog_cfg_t;

  typedef struct packed {
    logic                     valid;
    logic                     other_acc;
    logic [`WWDOG_KEY_W-1:0]  data;
  } wwdog_feed_t;

  typedef enum logic [1:0] {
    WWDOG_FEED_IDLE,
    WWDOG_FEED_HALF
  } wwdog_feed_st_t;
endpackage

// [hw/wwdog_prescale.sv]
`timescale 1ns/1ps
`include "wwdog_map.svh"
module wwdog_prescale
  import wwdog_pkg::*;
#(
  parameter int DIV = `WWDOG_PRE_DIV
) (
  input  wire logic i_core_clk,
  input  wire logic i_rst_n,
  input  wire logic i_run,
  output logic      o_tick
);
  // =====================================================
  // divider
  logic [$clog2(DIV)-1:0] cnt_r;
  wire                    wrap = (cnt_r == ($clog2(DIV))'(DIV - 1));

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_r  <= '0;
      o_tick <= 1'b0;
    end else begin
      cnt_r  <= (!i_run || wrap) ? '0 : cnt_r + 1'b1;
      o_tick <= i_run && wrap;
    end
  end
endmodule

// [test/wwdog_chk.sv]
`timescale 1ns/1ps
// ==========
// checker
module wwdog_chk
  import wwdog_pkg::*;
#(
  parameter int PRE_DIV = 4
) (
  input wire logic        i_core_clk,
  input wire logic        i_reset_n,
  input wire logic        i_por,
  input wire logic        i_cfg_we,
  input wire wwdog_feed_t i_feed,
  input wire logic        o_chip_reset,
  input wire logic        o_wdog_irq,
  input wire logic        o_enabled,
  input wire logic        o_timeout_flag,
  input wire logic        o_wdrst_flag,
  input wire logic [23:0] o_count
);
  localparam int EV_MAX = PRE_DIV + 1;
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_reset_n);
  sequence s_event;
    o_chip_reset || o_wdog_irq;
  endsequence
  sequence s_bad_key;
    o_enabled && i_feed.valid && i_feed.data != 8'hAA && i_feed.data != 8'h55;
  endsequence
  a_pulse_one: assert property (o_chip_reset |=> !o_chip_reset)
    else $error("chip reset too long");
  a_tout_fires: assert property (o_enabled && o_count == 24'h00_0000 && !i_feed.valid
    |-> ##[1:EV_MAX] s_event) else $error("no expiry");
  a_reset_flags: assert property (o_chip_reset |-> o_wdrst_flag && o_timeout_flag)
    else $error("flags missing");
  a_enable_stays: assert property (o_enabled ##1 !o_enabled
    |-> o_chip_reset || $rose(o_wdog_irq)) else $error("enable lost");
  a_irq_mode: assert property ($rose(o_wdog_irq) |-> !o_chip_reset && o_timeout_flag)
    else $error("irq mode wrong");
  a_bad_key: assert property (s_bad_key |=> s_event)
    else $error("bad key ignored");
  a_count_step: assert property (o_enabled && $past(o_enabled) && $changed(o_count)
    && !$past(i_cfg_we) && !$past(i_feed.valid) |-> o_count == $past(o_count) - 24'h00_0001)
    else $error("bad count step");
  a_por_clears: assert property (i_por ##1 i_por |-> !o_wdrst_flag)
    else $error("flag not cleared");
endmodule
bind wwdog_top wwdog_chk #(.PRE_DIV(PRE_DIV)) u_chk (.*);

// [test/tb_top.sv]
`timescale 1ns/1ps
module tb_top import wwdog_pkg::*; ;
  logic clk = 0, rst_n = 0, por = 1, we = 0, tclr = 0, fclr = 0;
  logic cr, wi, wa, en, tf, rf;
  logic [23:0] cnt;
  wwdog_cfg_t cfg = '0;
  wwdog_feed_t fd = '0;
  int failures = 0, check_count = 0, n;
  always #25 clk = ~clk;
  wwdog_top #(.PRE_DIV(4)) u_dut (.i_core_clk(clk), .i_reset_n(rst_n), .i_por(por),
    .i_cfg_we(we), .i_cfg(cfg), .i_feed(fd), .i_warn_clr(tclr), .i_tout_clr(tclr),
    .i_wdrst_flag_clr(fclr), .o_chip_reset(cr), .o_wdog_irq(wi), .o_warn_irq(wa),
    .o_enabled(en), .o_timeout_flag(tf), .o_wdrst_flag(rf), .o_count(cnt));
  // ==========
  // tasks
  task automatic chk(input logic [23:0] s, input logic [23:0] e);
    check_count++;
    if (s !== e) begin
      failures++;
      $display("Error %0t: saw %h want %h", $time, s, e);
    end
  endtask
  task automatic setup(input logic e, input logic r, input logic [23:0] t, input logic [23:0] w);
    @(negedge clk);
    tclr = 0;
    cfg = '{e, r, t, w, 24'h00_0001};
    we = 1;
    @(negedge clk);
    we = 0;
  endtask
  task automatic feed(input logic [7:0] d, input logic oa);
    @(negedge clk);
    fd = '{~oa, oa, d};
    @(negedge clk);
    fd = '0;
  endtask
  // bounded wait so a silent watchdog cannot hang the run
  task automatic wait_ev(input int lim);
    n = 0;
    while (cr !== 1'b1 && wi !== 1'b1 && n < lim) begin
      @(negedge clk);
      n++;
    end
    chk(24'(n < lim), 24'h00_0001);
  endtask
  // chip reset in mid-run: clears the watchdog but not the reset flag
  task automatic reboot;
    @(negedge clk);
    rst_n = 0;
    repeat (2) @(negedge clk);
    rst_n = 1;
    repeat (3) @(negedge clk);
  endtask
  task automatic end_of_test;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // ==========
  // tests
  initial begin
    repeat (6) @(negedge clk);
    rst_n = 1;
    por = 0;
    repeat (3) @(negedge clk);
    chk(cnt, 24'h00_00FF);
    setup(1, 1, 24'h00_0003, 24'hFF_FFFF);
    setup(0, 0, 24'h00_0003, 24'hFF_FFFF);
    chk(24'(en), 24'h00_0001);
    wait_ev(40);
    chk(24'({cr, rf, tf, wa, en}), 24'h00_001E);
    tclr = 1;
    @(negedge clk);
    tclr = 0;
    chk(24'({tf, wa, rf}), 24'h00_0001);
    $display("test expiry done");
    reboot();
    chk(24'({rf, en}), 24'h00_0002);
    por = 1;
    repeat (2) @(negedge clk);
    por = 0;
    chk(24'(rf), 24'h00_0000);
    $display("test reset flag done");
    setup(1, 0, 24'h00_0100, 24'hFF_FFFF);
    feed(8'h12, 0);
    wait_ev(3);
    chk(24'({wi, cr, en}), 24'h00_0004);
    tclr = 1;
    setup(1, 0, 24'h00_0100, 24'hFF_FFFF);
    feed(8'hAA, 0);
    feed(8'h00, 1);
    feed(8'h55, 0);
    wait_ev(3);
    tclr = 1;
    setup(1, 0, 24'h00_0100, 24'h00_0010);
    feed(8'hAA, 0);
    feed(8'h55, 0);
    wait_ev(3);
    tclr = 1;
    setup(1, 0, 24'h00_0100, 24'hFF_FFFF);
    repeat (20) @(negedge clk);
    feed(8'hAA, 0);
    feed(8'h55, 0);
    chk(24'({wi, en, cnt > 24'h00_00FC}), 24'h00_0003);
    $display("test feed done");
    reboot();
    setup(1, 1, 24'h00_0003, 24'hFF_FFFF);
    wait_ev(40);
    chk(24'(rf), 24'h00_0001);
    fclr = 1;
    @(negedge clk);
    fclr = 0;
    chk(24'(rf), 24'h00_0000);
    $display("test flag clear done");
    end_of_test();
  end
  initial begin
    #100000;
    failures++;
    end_of_test();
  end
endmodule
